// [ets_pkg.sv]
// event time-stamp unit: shared register map, field layout and timing constants
// assumes a single 100 MHz clock domain and a byte-wide register port
package ets_pkg;

  // register offsets (5-bit byte pointer)
  localparam logic [4:0] ETS_ADDR_SEC = 5'h00;
  localparam logic [4:0] ETS_ADDR_MIN = 5'h01;
  localparam logic [4:0] ETS_ADDR_HOUR = 5'h02;
  localparam logic [4:0] ETS_ADDR_DATE = 5'h03;
  localparam logic [4:0] ETS_ADDR_MONTH = 5'h04;
  localparam logic [4:0] ETS_ADDR_YEAR = 5'h05;
  localparam logic [4:0] ETS_ADDR_CLK_LAST = 5'h06;
  localparam logic [4:0] ETS_ADDR_STATUS = 5'h07;
  localparam logic [4:0] ETS_ADDR_EVENT_CFG = 5'h09;
  localparam logic [4:0] ETS_ADDR_TS_FIRST = 5'h14;
  localparam logic [4:0] ETS_ADDR_TS_LAST = 5'h19;

  // event_config fields
  localparam int ETS_CFG_DETECT_EN = 0;
  localparam int ETS_CFG_RATE_LO = 1;
  localparam int ETS_CFG_FILT_LO = 3;
  localparam int ETS_CFG_HALT = 5;
  localparam int ETS_CFG_BACKUP_OFF = 6;
  localparam int ETS_CFG_SOURCE_OFF = 7;
  localparam logic [7:0] ETS_CFG_RESET = 8'h00;

  // status register field
  localparam int ETS_STAT_EVENT_FLAG = 0;

  // base sampling tick from the 32.768 kHz time base
  localparam int ETS_CLK_PERIOD_NS = 10;
  localparam int ETS_TICK_PERIOD_NS = 30517;
  localparam int ETS_TICK_CYCLES = ETS_TICK_PERIOD_NS / ETS_CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } ets_time_s;

  typedef enum logic [1:0] {
    ETS_RUN = 2'b01,
    ETS_HALT = 2'b10
  } ets_clk_e;

endpackage

// [ets_sampler.sv]
// event input synchroniser, rate-selectable sampler and glitch filter
// assumes the event input is asynchronous to CLK; emits a one-cycle rise pulse
module ets_sampler #(
  parameter int TICK_CYCLES = ets_pkg::ETS_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // event pin and conditioning
  input wire logic event_pin,
  input wire logic run,
  input wire logic [1:0] rate_sel,
  input wire logic [1:0] filt_sel,
  // detected rising edge
  output logic rise_pulse
);
  import ets_pkg::*;

  logic sync1_r, sync2_r;
  logic [11:0] tick_cnt_r;
  logic [2:0] rate_cnt_r;
  logic [3:0] stab_cnt_r;
  logic level_r;
  logic sample_en;
  logic [3:0] need;

  // two-stage synchroniser; first stage read only by the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= event_pin;
      sync2_r <= sync1_r;
    end
  end

  // base tick divided by 1, 2, 4 or 8; slower rate means later detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_r <= 12'h000;
      rate_cnt_r <= 3'h0;
    end else if (tick_cnt_r == 12'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 12'h000;
      rate_cnt_r <= rate_cnt_r + 3'h1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 12'h001;
    end
  end

  always_comb begin
    sample_en = 1'b0;
    if (run && tick_cnt_r == 12'(TICK_CYCLES - 1)) begin
      case (rate_sel)
        2'b00: sample_en = 1'b1;
        2'b01: sample_en = (rate_cnt_r[0] == 1'b1);
        2'b10: sample_en = (rate_cnt_r[1:0] == 2'b11);
        default: sample_en = (rate_cnt_r == 3'h7);
      endcase
    end
    need = 4'h1 << filt_sel;
  end

  // filter counts sample points only, so it cannot act without sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= 1'b0;
      stab_cnt_r <= 4'h0;
    end else if (sample_en) begin
      if (sync2_r == level_r) begin
        stab_cnt_r <= 4'h0;
      end else if (stab_cnt_r + 4'h1 >= need) begin
        level_r <= sync2_r;
        stab_cnt_r <= 4'h0;
      end else begin
        stab_cnt_r <= stab_cnt_r + 4'h1;
      end
    end
  end

  // high level is the asserted condition; event on its rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_pulse <= 1'b0;
    end else begin
      rise_pulse <= sample_en && sync2_r && !level_r && (stab_cnt_r + 4'h1 >= need);
    end
  end

  a_rise_needs_run: assert property (@(posedge clk) disable iff (!rst_n)
    !run |=> !rise_pulse) else $error("event rise while sampling stopped");
  a_rise_sets_level: assert property (@(posedge clk) disable iff (!rst_n)
    rise_pulse |-> level_r && !$past(level_r)) else $error("rise without level change");

endmodule

// [ets_event_timestamp.sv]
// event detect and time-stamp unit of a real time clock
// assumes the serial bus slave drives the byte register port and the clock
// counters sit outside, honouring CLOCK_HALT and presenting RTC_TIME
module ets_event_timestamp #(
  parameter int TICK_CYCLES = ets_pkg::ETS_TICK_CYCLES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // event pin and supply state
  input wire logic EVENT_INPUT,
  input wire logic ON_BATTERY,
  // running clock/calendar counters
  input wire ets_pkg::ets_time_s RTC_TIME,
  // byte register port
  input wire logic REG_PTR_LOAD,
  input wire logic [4:0] REG_PTR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  // event outputs
  output logic EVENT_FLAG,
  output logic EVENT_DETECT_OUT_N,
  output logic CLOCK_HALT,
  output logic INPUT_SOURCE_OFF
);
  import ets_pkg::*;

  function automatic logic [4:0] next_ptr(input logic [4:0] p);
    next_ptr = (p == ETS_ADDR_TS_LAST) ? 5'h00 : p + 5'h01;
  endfunction

  logic [7:0] cfg_r;
  logic [4:0] ptr_r;
  logic event_flag_r;
  ets_time_s ts_r;
  ets_clk_e clk_st_r;
  logic ev_rise;
  logic flag_clr, clk_wr, sampling_run;

  assign sampling_run = !(ON_BATTERY && cfg_r[ETS_CFG_BACKUP_OFF]);
  assign flag_clr = REG_WR && !REG_PTR_LOAD && ptr_r == ETS_ADDR_STATUS
    && !REG_WDATA[ETS_STAT_EVENT_FLAG];
  assign clk_wr = REG_WR && !REG_PTR_LOAD && ptr_r <= ETS_ADDR_CLK_LAST;

  ets_sampler #(.TICK_CYCLES(TICK_CYCLES)) u_sampler (
    .clk(CLK),
    .rst_n(RST_N),
    .event_pin(EVENT_INPUT),
    .run(sampling_run),
    .rate_sel(cfg_r[ETS_CFG_RATE_LO +: 2]),
    .filt_sel(cfg_r[ETS_CFG_FILT_LO +: 2]),
    .rise_pulse(ev_rise)
  );

  // pointer: load, then one step per byte read or written, wrapping after 19h
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ptr_r <= 5'h00;
    end else if (REG_PTR_LOAD) begin
      ptr_r <= REG_PTR;
    end else if (REG_RD || REG_WR) begin
      ptr_r <= next_ptr(ptr_r);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cfg_r <= ETS_CFG_RESET;
    end else if (REG_WR && !REG_PTR_LOAD && ptr_r == ETS_ADDR_EVENT_CFG) begin
      cfg_r <= REG_WDATA;
    end
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      event_flag_r <= 1'b0;
    end else if (ev_rise) begin
      event_flag_r <= 1'b1;
    end else if (flag_clr) begin
      event_flag_r <= 1'b0;
    end
  end

  // power-on reset only; the bus has no write path to the stamp
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ts_r <= '0;
    end else if (ev_rise && !event_flag_r) begin
      ts_r <= RTC_TIME;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_st_r <= ETS_RUN;
    end else begin
      // stays halted until the host rewrites the time; an event in that cycle wins while the halt bit is set
      case (clk_st_r)
        ETS_RUN: if (ev_rise && cfg_r[ETS_CFG_HALT]) clk_st_r <= ETS_HALT;
        ETS_HALT: if (clk_wr && !(ev_rise && cfg_r[ETS_CFG_HALT])) clk_st_r <= ETS_RUN;
        default: clk_st_r <= ETS_RUN;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_DATA <= 8'h00;
      RD_VALID <= 1'b0;
    end else begin
      // registered answer, one cycle after the read strobe
      RD_VALID <= REG_RD && !REG_PTR_LOAD;
      if (REG_RD && !REG_PTR_LOAD) begin
        case (ptr_r)
          ETS_ADDR_SEC: RD_DATA <= RTC_TIME.second;
          ETS_ADDR_MIN: RD_DATA <= RTC_TIME.minute;
          ETS_ADDR_HOUR: RD_DATA <= RTC_TIME.hour;
          ETS_ADDR_DATE: RD_DATA <= RTC_TIME.date;
          ETS_ADDR_MONTH: RD_DATA <= RTC_TIME.month;
          ETS_ADDR_YEAR: RD_DATA <= RTC_TIME.year;
          ETS_ADDR_STATUS: RD_DATA <= 8'({event_flag_r} << ETS_STAT_EVENT_FLAG);
          ETS_ADDR_EVENT_CFG: RD_DATA <= cfg_r;
          ETS_ADDR_TS_FIRST: RD_DATA <= ts_r.second;
          ETS_ADDR_TS_FIRST + 5'h01: RD_DATA <= ts_r.minute;
          ETS_ADDR_TS_FIRST + 5'h02: RD_DATA <= ts_r.hour;
          ETS_ADDR_TS_FIRST + 5'h03: RD_DATA <= ts_r.date;
          ETS_ADDR_TS_FIRST + 5'h04: RD_DATA <= ts_r.month;
          ETS_ADDR_TS_LAST: RD_DATA <= ts_r.year;
          default: RD_DATA <= 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EVENT_FLAG <= 1'b0;
      EVENT_DETECT_OUT_N <= 1'b1;
      CLOCK_HALT <= 1'b0;
      INPUT_SOURCE_OFF <= 1'b0;
    end else begin
      // outputs trail the internal state by one cycle
      EVENT_FLAG <= event_flag_r;
      EVENT_DETECT_OUT_N <= !(event_flag_r && cfg_r[ETS_CFG_DETECT_EN]);
      CLOCK_HALT <= (clk_st_r == ETS_HALT);
      INPUT_SOURCE_OFF <= cfg_r[ETS_CFG_SOURCE_OFF];
    end
  end

  a_capture_time: assert property (@(posedge CLK) disable iff (!RST_N)
    ev_rise && !event_flag_r |=> ts_r == $past(RTC_TIME))
    else $error("stamp does not hold clock at event");
  a_hold_first: assert property (@(posedge CLK) disable iff (!RST_N)
    event_flag_r |=> $stable(ts_r)) else $error("stamp changed while flag set");
  a_flag_set: assert property (@(posedge CLK) disable iff (!RST_N)
    ev_rise |=> event_flag_r ##1 EVENT_FLAG) else $error("flag not set by event");
  a_halt_on_event: assert property (@(posedge CLK) disable iff (!RST_N)
    ev_rise && cfg_r[ETS_CFG_HALT] |=> ##1 CLOCK_HALT) else $error("clock not halted");
  a_halt_release: assert property (@(posedge CLK) disable iff (!RST_N)
    clk_st_r == ETS_HALT && clk_wr && !ev_rise |=> ##1 !CLOCK_HALT)
    else $error("clock not resumed after write");
  a_ptr_wrap: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_RD && !REG_PTR_LOAD && ptr_r == ETS_ADDR_TS_LAST |=> ptr_r == 5'h00)
    else $error("pointer did not wrap");
  a_source_off: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_WR && !REG_PTR_LOAD && ptr_r == ETS_ADDR_EVENT_CFG
    |=> ##1 INPUT_SOURCE_OFF == $past(REG_WDATA[ETS_CFG_SOURCE_OFF], 2))
    else $error("source off bit not applied");
  a_no_halt_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    !cfg_r[ETS_CFG_HALT] && clk_st_r == ETS_RUN |=> clk_st_r == ETS_RUN)
    else $error("halt without halt bit");

  // stamp, register, halt, detect output and backup checks
  a_stamp_locked: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_WR && !ev_rise |=> $stable(ts_r))
    else $error("bus write changed the stamp");
  a_clear_keeps_stamp: assert property (@(posedge CLK) disable iff (!RST_N)
    !event_flag_r && !ev_rise |=> $stable(ts_r))
    else $error("stamp changed without an event");
  a_halt_again: assert property (@(posedge CLK) disable iff (!RST_N)
    clk_st_r == ETS_RUN && ev_rise && cfg_r[ETS_CFG_HALT] |=> clk_st_r == ETS_HALT)
    else $error("clock not halted again");
  a_backup_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
    ON_BATTERY && cfg_r[ETS_CFG_BACKUP_OFF] |=> !ev_rise)
    else $error("event seen with backup sampling off");
  a_detect_low: assert property (@(posedge CLK) disable iff (!RST_N)
    event_flag_r && cfg_r[ETS_CFG_DETECT_EN] |=> !EVENT_DETECT_OUT_N)
    else $error("detect output not asserted");
  a_read_answer: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_RD && !REG_PTR_LOAD |=> RD_VALID)
    else $error("read not answered");
  a_cfg_store: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_WR && !REG_PTR_LOAD && ptr_r == ETS_ADDR_EVENT_CFG |=> cfg_r == $past(REG_WDATA))
    else $error("config write lost");
  a_flag_clear: assert property (@(posedge CLK) disable iff (!RST_N)
    flag_clr && !ev_rise |=> !event_flag_r)
    else $error("flag not cleared by status write");
  a_stamp_read: assert property (@(posedge CLK) disable iff (!RST_N)
    REG_RD && !REG_PTR_LOAD && ptr_r == ETS_ADDR_TS_FIRST |=> RD_DATA == $past(ts_r.second))
    else $error("stamp second read wrong");

endmodule

// [ets_evt_src.sv]
// enclosure switch model driving the event pin
// assumes pulse() is called from a process in step with clk
module ets_evt_src (
  // clock
  input wire logic clk,
  // event pin
  output logic event_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // closed switch keeps the pin low between events
  initial event_pin = 1'b0;
  task automatic pulse(input int n);
    @(posedge clk);
    event_pin <= 1'b1;
    repeat (n) @(posedge clk);
    event_pin <= 1'b0;
  endtask
endmodule

// [ets_event_timestamp_tb.sv]
// self-checking bench for the event time-stamp unit
// assumes the unit runs with a short sampling tick of 4 clocks
module ets_event_timestamp_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ets_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic on_bat = 1'b0;
  logic ld = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [4:0] ptr = 5'h00;
  logic [7:0] wd = 8'h00;
  ets_time_s rtc = '0;
  wire logic event_pin;
  logic [7:0] rdat;
  logic rval, flag, det_n, halt, src_off;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  localparam ets_time_s T1 = 48'h231231235959;
  localparam ets_time_s T2 = 48'h240101000001;

  ets_evt_src i_src (.clk(clk), .event_pin(event_pin));
  ets_event_timestamp #(.TICK_CYCLES(4)) i_dut (
    .CLK(clk), .RST_N(rst_n), .EVENT_INPUT(event_pin), .ON_BATTERY(on_bat), .RTC_TIME(rtc),
    .REG_PTR_LOAD(ld), .REG_PTR(ptr), .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd),
    .RD_DATA(rdat), .RD_VALID(rval), .EVENT_FLAG(flag), .EVENT_DETECT_OUT_N(det_n),
    .CLOCK_HALT(halt), .INPUT_SOURCE_OFF(src_off)
  );

  always #5 clk = ~clk;

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // whole run is a few thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    ld <= 1'b1;
    ptr <= a;
    @(posedge clk);
    ld <= 1'b0;
    wr <= 1'b1;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // back-to-back reads, pointer steps on its own
  task automatic rreg(input logic [4:0] a, input int n, input logic [47:0] e);
    @(posedge clk);
    ld <= 1'b1;
    ptr <= a;
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      ld <= 1'b0;
      rd <= (i < n);
      if (i > 0) begin
        #1;
        chk({7'h00, rval}, 8'h01);
        chk(rdat, e[8*(i-1) +: 8]);
      end
    end
  endtask

  task automatic ev(input int n, input int w);
    i_src.pulse(n);
    repeat (w) @(posedge clk);
    #1;
  endtask

  task automatic flag_is(input logic e);
    chk({7'h00, flag}, {7'h00, e});
  endtask

  // a bounce too short for the filter, then an event long enough to pass
  task automatic filt_case(input logic [7:0] c, input int s, input int l, input int w);
    wreg(ETS_ADDR_STATUS, 8'h00);
    wreg(ETS_ADDR_EVENT_CFG, c);
    ev(s, w);
    flag_is(1'b0);
    ev(l, w);
    flag_is(1'b1);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk({4'h0, flag, det_n, halt, src_off}, 8'h04);
    rreg(ETS_ADDR_EVENT_CFG, 1, 48'h000000000000);
    @(posedge clk) rtc <= T1;
    wreg(ETS_ADDR_EVENT_CFG, 8'h01);
    rreg(ETS_ADDR_EVENT_CFG, 1, 48'h000000000001);
    ev(12, 20);
    chk({6'h00, flag, det_n}, 8'h02);
    rreg(ETS_ADDR_TS_FIRST, 6, T1);
    wreg(ETS_ADDR_TS_FIRST, 8'h00);
    rreg(ETS_ADDR_TS_FIRST, 6, T1);
    @(posedge clk) rtc <= T2;
    ev(12, 20);
    rreg(ETS_ADDR_TS_FIRST, 6, T1);
    wreg(ETS_ADDR_STATUS, 8'h00);
    @(posedge clk);
    #1;
    flag_is(1'b0);
    rreg(ETS_ADDR_TS_FIRST, 6, T1);
    ev(12, 20);
    rreg(ETS_ADDR_TS_FIRST, 6, T2);
    wreg(ETS_ADDR_STATUS, 8'h00);
    wreg(ETS_ADDR_EVENT_CFG, 8'h21);
    ev(12, 20);
    chk({7'h00, halt}, 8'h01);
    wreg(ETS_ADDR_SEC, 8'h00);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, halt}, 8'h00);
    ev(12, 20);
    chk({7'h00, halt}, 8'h01);
    rreg(ETS_ADDR_TS_LAST, 2, 48'h000000000124);
    wreg(ETS_ADDR_STATUS, 8'h00);
    wreg(ETS_ADDR_EVENT_CFG, 8'h41);
    on_bat <= 1'b1;
    ev(12, 20);
    flag_is(1'b0);
    @(posedge clk) on_bat <= 1'b0;
    ev(12, 20);
    flag_is(1'b1);
    // on battery with backup sampling left on, events still count
    wreg(ETS_ADDR_STATUS, 8'h00);
    wreg(ETS_ADDR_EVENT_CFG, 8'h01);
    on_bat <= 1'b1;
    ev(12, 20);
    flag_is(1'b1);
    @(posedge clk) on_bat <= 1'b0;
    filt_case(8'h0B, 4, 40, 60);
    filt_case(8'h15, 12, 120, 150);
    // slowest rate with the longest filter: a short bounce must not count
    wreg(ETS_ADDR_STATUS, 8'h00);
    wreg(ETS_ADDR_EVENT_CFG, 8'h1F);
    ev(40, 600);
    flag_is(1'b0);
    ev(400, 700);
    flag_is(1'b1);
    wreg(ETS_ADDR_EVENT_CFG, 8'h80);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, src_off}, 8'h01);
    end_of_test();
  end
endmodule
